// *** core/srmb_consts.vh ***
// constants of the two-wire memory bus front end
`ifndef SRMB_CONSTS_VH
`define SRMB_CONSTS_VH

// select byte type identifiers
`define SRMB_TYPE_ARRAY 4'ha
`define SRMB_TYPE_IDPG 4'hb

// select byte field positions
`define SRMB_SEL_TYPE_HI 7
`define SRMB_SEL_TYPE_LO 4
`define SRMB_SEL_CE_BIT 3
`define SRMB_SEL_ADDR_HI 2
`define SRMB_SEL_ADDR_LO 1
`define SRMB_SEL_DIR_BIT 0

// address byte field positions
`define SRMB_ADDR_PAGE_BIT 7
`define SRMB_ADDR_IDX_HI 3
`define SRMB_ADDR_IDX_LO 0

// bit counting
`define SRMB_BYTE_BITS 4'h8
`define SRMB_CNT_ZERO 4'h0
`define SRMB_CNT_ONE 4'h1

// reset values
`define SRMB_ARRAY_ADDR_RST 10'h000
`define SRMB_ID_INDEX_RST 4'h0
`define SRMB_BYTE_RST 8'h00

`endif

// *** core/srmb_frontend.v ***
// two-wire target front end of a serial memory, with its receive fifo
`timescale 1ns/1ps
`include "srmb_consts.vh"

// ****************************************************************
// receive fifo
// ****************************************************************
module srmb_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  reg [AW:0] count_d;
  wire push;
  wire pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_q[rd_ptr_q];

  always @*
  begin
    count_d = count_q;
    if (push & ~pop)
      count_d = count_q + 1'b1;
    else if (pop & ~push)
      count_d = count_q - 1'b1;
  end

  // flags follow the next count so they are flip-flops, not decode
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_ptr_q] <= in_data;
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q <= count_d;
      in_ready <= (count_d != DEPTH[AW:0]);
      out_valid <= (count_d != {(AW+1){1'b0}});
    end
  end
endmodule // srmb_fifo

// What this block does
// - start is data falling while clock high
// - watch for start except during write cycle
// - stop is data rising with clock high; ends transfer
// - stop after write data ack starts write
// - capture data bit on rising clock edge
// - release after eight bits; receiver acks ninth
// - ack only type 1010b or 1011b
// - chip-enable bit must equal strap level
// - select bit zero: one read, zero write
// - select layout: type, enable, a9 a8, direction
// - page access ignores select bits two, one
// - bytes arrive most significant bit first
// - mismatch releases bus, standby until start
// - matched select acked, then address acked on write select only
// - array address is a9 a8 plus byte
// - page b7 zero index b3..b0; lock b7 one
// - always target, never initiates transfers
// - write protect nacks data bytes only
module srmb_frontend #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  input wire chip_enable_strap,
  input wire write_protect_input,
  input wire write_busy,
  output reg start_pulse,
  output reg stop_pulse,
  output reg sel_active,
  output reg sel_id_page,
  output reg sel_read,
  output reg addr_valid,
  output reg [9:0] array_addr,
  output reg [3:0] id_index,
  output reg lock_cmd,
  output reg write_start,
  output reg rx_valid,
  input wire rx_ready,
  output reg [7:0] rx_data
);
  // ****************************************************************
  // states
  // ****************************************************************
  localparam ST_IDLE = 3'b000;
  localparam ST_SEL = 3'b001;
  localparam ST_ADDR = 3'b010;
  localparam ST_DATA = 3'b011;
  localparam ST_HOLD = 3'b100;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg scl_m_q, scl_s_q, scl_p_q;
  reg sda_m_q, sda_s_q, sda_p_q;
  reg ce_m_q, ce_s_q;
  reg wp_m_q, wp_s_q;

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      ce_m_q <= 1'b0;
      ce_s_q <= 1'b0;
      wp_m_q <= 1'b0;
      wp_s_q <= 1'b0;
    end
    else
    begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      ce_m_q <= chip_enable_strap;
      ce_s_q <= ce_m_q;
      wp_m_q <= write_protect_input;
      wp_s_q <= wp_m_q;
    end
  end

  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire scl_high = scl_s_q & scl_p_q;
  // ack drive only moves while the clock is low, so it never fakes these
  wire start_det = scl_high & sda_p_q & ~sda_s_q & ~write_busy;
  wire stop_det = scl_high & ~sda_p_q & sda_s_q;

  // ****************************************************************
  // byte engine and decode
  // ****************************************************************
  reg [2:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg ack_slot_q;
  reg wr_armed_q;
  reg push_q;
  reg [7:0] push_data_q;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;

  wire [3:0] sel_type = shift_q[`SRMB_SEL_TYPE_HI:`SRMB_SEL_TYPE_LO];
  wire type_ok = (sel_type == `SRMB_TYPE_ARRAY) | (sel_type == `SRMB_TYPE_IDPG);
  wire ce_ok = (shift_q[`SRMB_SEL_CE_BIT] == ce_s_q);
  wire byte_end = (bit_cnt_q == `SRMB_BYTE_BITS) & ~ack_slot_q;
  // a full fifo refuses the byte with nack: back-pressure the master can see
  wire data_ack = ~wp_s_q & fifo_in_ready & ~push_q;

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      bit_cnt_q <= `SRMB_CNT_ZERO;
      shift_q <= `SRMB_BYTE_RST;
      ack_slot_q <= 1'b0;
      wr_armed_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= `SRMB_BYTE_RST;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      start_pulse <= 1'b0;
      stop_pulse <= 1'b0;
      sel_active <= 1'b0;
      sel_id_page <= 1'b0;
      sel_read <= 1'b0;
      addr_valid <= 1'b0;
      array_addr <= `SRMB_ARRAY_ADDR_RST;
      id_index <= `SRMB_ID_INDEX_RST;
      lock_cmd <= 1'b0;
      write_start <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      start_pulse <= 1'b0;
      stop_pulse <= 1'b0;
      addr_valid <= 1'b0;
      write_start <= 1'b0;
      if (push_q & fifo_in_ready)
        push_q <= 1'b0;
      if (start_det)
      begin
        // restart select reception from any point of a transfer
        state_q <= ST_SEL;
        bit_cnt_q <= `SRMB_CNT_ZERO;
        ack_slot_q <= 1'b0;
        wr_armed_q <= 1'b0;
        sda_oe_n <= 1'b1;
        sel_active <= 1'b0;
        start_pulse <= 1'b1;
      end
      else if (stop_det)
      begin
        if (wr_armed_q & ~sel_read)
          write_start <= 1'b1;
        state_q <= ST_IDLE;
        bit_cnt_q <= `SRMB_CNT_ZERO;
        ack_slot_q <= 1'b0;
        wr_armed_q <= 1'b0;
        sda_oe_n <= 1'b1;
        sel_active <= 1'b0;
        stop_pulse <= 1'b1;
      end
      else if ((state_q == ST_SEL) | (state_q == ST_ADDR) | (state_q == ST_DATA))
      begin
        if (scl_rise & ~ack_slot_q)
        begin
          shift_q <= {shift_q[6:0], sda_s_q};
          bit_cnt_q <= bit_cnt_q + `SRMB_CNT_ONE;
          // a stop has to raise the clock once first, so only the second rise disarms
          wr_armed_q <= wr_armed_q & (bit_cnt_q == `SRMB_CNT_ZERO);
        end
        else if (scl_fall & byte_end)
        begin
          ack_slot_q <= 1'b1;
          case (state_q)
            ST_SEL:
            begin
              if (type_ok & ce_ok)
              begin
                sda_oe_n <= 1'b0;
                sel_active <= 1'b1;
                sel_id_page <= (sel_type == `SRMB_TYPE_IDPG);
                sel_read <= shift_q[`SRMB_SEL_DIR_BIT];
                if (sel_type == `SRMB_TYPE_ARRAY)
                  // page access leaves the upper address bits alone
                  array_addr[9:8] <= shift_q[`SRMB_SEL_ADDR_HI:`SRMB_SEL_ADDR_LO];
              end
            end
            ST_ADDR:
            begin
              sda_oe_n <= 1'b0;
              addr_valid <= 1'b1;
              if (sel_id_page)
              begin
                lock_cmd <= shift_q[`SRMB_ADDR_PAGE_BIT];
                id_index <= shift_q[`SRMB_ADDR_IDX_HI:`SRMB_ADDR_IDX_LO];
              end
              else
              begin
                lock_cmd <= 1'b0;
                array_addr[7:0] <= shift_q;
              end
            end
            ST_DATA:
            begin
              if (data_ack)
              begin
                sda_oe_n <= 1'b0;
                wr_armed_q <= 1'b1;
                push_q <= 1'b1;
                push_data_q <= shift_q;
              end
            end
            default:
            begin
              sda_oe_n <= 1'b1;
            end
          endcase
        end
        else if (scl_fall & ack_slot_q)
        begin
          sda_oe_n <= 1'b1;
          ack_slot_q <= 1'b0;
          bit_cnt_q <= `SRMB_CNT_ZERO;
          case (state_q)
            ST_SEL:
            begin
              if (~sel_active)
                state_q <= ST_IDLE;
              else if (sel_read)
                // read data path lives outside this block
                state_q <= ST_HOLD;
              else
                state_q <= ST_ADDR;
            end
            ST_ADDR:
              state_q <= ST_DATA;
            ST_DATA:
              state_q <= ST_DATA;
            default:
              state_q <= ST_IDLE;
          endcase
        end
      end
      else
      begin
        sda_oe_n <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // receive fifo and its output stage
  // ****************************************************************
  srmb_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(push_data_q),
    .out_valid(fifo_out_valid),
    .out_ready(~rx_valid | rx_ready),
    .out_data(fifo_out_data)
  );

  // skid register keeps rx outputs on flip-flops
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rx_valid <= 1'b0;
      rx_data <= `SRMB_BYTE_RST;
    end
    else if (~rx_valid | rx_ready)
    begin
      rx_valid <= fifo_out_valid;
      if (fifo_out_valid)
        rx_data <= fifo_out_data;
    end
  end
endmodule // srmb_frontend

// *** testbench/srmb_bus_master.sv ***
// two-wire bus master model driving the front end's pins
`timescale 1ns/1ps
module srmb_bus_master (
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  // ****************************************************************
  // bus cycles, 400 ns per bit
  // ****************************************************************
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // odd offset keeps pin edges off the system clock edges
  task automatic start;
    #157.3 sda_m = 1'b1;
    #150 scl = 1'b1;
    #200 sda_m = 1'b0;
    #200 scl = 1'b0;
  endtask
  task automatic stop;
    #107.3 sda_m = 1'b0;
    #100 scl = 1'b1;
    #200 sda_m = 1'b1;
    #200;
  endtask
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      #100 sda_m = b[i];
      #100 scl = 1'b1;
      #200 scl = 1'b0;
    end
    #100 sda_m = 1'b1;
    #100 scl = 1'b1;
    #100 ack = !sda;
    #100 scl = 1'b0;
  endtask
endmodule // srmb_bus_master

// *** testbench/srmb_frontend_monitor.sv ***
// assertion checker of the two-wire memory front end
`timescale 1ns/1ps
module srmb_frontend_checker (
  input wire clk_sys,
  input wire sys_rst,
  input wire sda_out,
  input wire sda_oe_n,
  input wire write_busy,
  input wire start_pulse,
  input wire stop_pulse,
  input wire sel_active,
  input wire sel_id_page,
  input wire addr_valid,
  input wire [9:0] array_addr,
  input wire lock_cmd,
  input wire write_start,
  input wire rx_valid,
  input wire rx_ready,
  input wire [7:0] rx_data
);
  // ****************************************************************
  // bus and stream properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // ack holds one bus clock period, eight system clocks in the bench
  sequence ack_slot;
    (!sda_oe_n) [*6] ##[1:4] sda_oe_n;
  endsequence
  sequence busy_held;
    write_busy [*3];
  endsequence
  busy_blocks_a: assert property (busy_held |=> !start_pulse)
    else $error("start taken while busy");
  start_resets_a: assert property (start_pulse |=> !sel_active)
    else $error("select kept over start");
  stop_ends_a: assert property (stop_pulse |=> !sel_active && sda_oe_n)
    else $error("select kept over stop");
  write_on_stop_a: assert property (write_start |-> stop_pulse)
    else $error("write start without stop");
  ack_width_a: assert property ($fell(sda_oe_n) |-> ack_slot)
    else $error("ack slot of wrong length");
  open_drain_a: assert property (!sda_out)
    else $error("data line driven high");
  select_ack_a: assert property ($rose(sel_active) |-> ##[0:1] !sda_oe_n)
    else $error("select taken without ack");
  addr_ack_a: assert property (addr_valid |-> ##[0:1] !sda_oe_n && sel_active)
    else $error("address taken without ack");
  page_keeps_a: assert property (addr_valid && sel_id_page |-> $stable(array_addr))
    else $error("page access moved array address");
  lock_page_a: assert property (addr_valid && !sel_id_page |-> !lock_cmd)
    else $error("lock flagged on array access");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("stream word dropped");
endmodule // srmb_frontend_checker

bind srmb_frontend srmb_frontend_checker chk (.*);

// *** testbench/tb.sv ***
// self-checking bench of the two-wire memory front end
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0, sys_rst = 1'b1, chip_enable_strap = 1'b1, write_protect_input = 1'b0;
  logic write_busy = 1'b0, rx_ready = 1'b0, stall = 1'b0, sda_m, ack;
  logic [7:0] d8;
  logic [15:0] seed = 16'hda16;
  logic [7:0] qd[$];
  logic [15:0] qa[$];
  int errors = 0, checks = 0, wcount = 0, n;
  wire scl_in, sda_out, sda_oe_n, start_pulse, stop_pulse, sel_active, sel_id_page, sel_read;
  wire addr_valid, lock_cmd, write_start, rx_valid;
  wire [9:0] array_addr;
  wire [3:0] id_index;
  wire [7:0] rx_data;
  wire [15:0] addr_seen = {array_addr, id_index, lock_cmd, sel_read};
  // pull-up on the data line: whoever pulls low wins
  wire sda_in = sda_m & sda_oe_n;
  always #25 clk_sys = ~clk_sys;
  srmb_bus_master bm (.scl(scl_in), .sda_m(sda_m), .sda(sda_in));
  srmb_frontend DUT (.*);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic send(input logic [7:0] b, input logic exp);
    bm.xfer(b, ack);
    cmp("ack", exp, ack);
  endtask
  task automatic frame(input logic [7:0] b, input logic exp);
    bm.start();
    send(b, exp);
  endtask
  task automatic data(input logic exp);
    d8 = seed[11:4];
    if (exp)
      qd.push_back(d8);
    send(d8, exp);
  endtask
  // an empty queue yields x, so any surplus result is a mismatch
  always @(posedge clk_sys)
  begin
    seed <= lfsr(seed);
    rx_ready <= !stall && seed[0];
    if (write_start === 1'b1)
      wcount++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      cmp("rx_data", qd.size() != 0 ? qd.pop_front() : 8'hxx, rx_data);
    if (addr_valid === 1'b1)
      cmp("addr", qa.size() != 0 ? qa.pop_front() : 16'hxxxx, addr_seen);
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk_sys);
    frame(8'hac, 1'b1);
    qa.push_back({10'h250, 4'h0, 2'b00});
    send(8'h50, 1'b1);
    repeat (3) data(1'b1);
    bm.stop();
    for (int t = 0; t < 16; t++)
    begin
      frame({t[3:0], 4'h8}, t == 10 || t == 11);
      bm.stop();
    end
    @(posedge clk_sys) chip_enable_strap <= 1'b0;
    frame(8'ha8, 1'b0);
    frame(8'ha1, 1'b1);
    cmp("sel_read", 1'b1, sel_read);
    bm.stop();
    @(posedge clk_sys) chip_enable_strap <= 1'b1;
    frame(8'hac, 1'b1);
    frame(8'hbe, 1'b1);
    qa.push_back({10'h250, 4'hb, 2'b00});
    send(8'h7b, 1'b1);
    data(1'b1);
    bm.stop();
    frame(8'hb8, 1'b1);
    qa.push_back({10'h250, 4'hb, 2'b10});
    send(8'h8b, 1'b1);
    data(1'b1);
    bm.stop();
    @(posedge clk_sys) write_protect_input <= 1'b1;
    frame(8'hac, 1'b1);
    qa.push_back({10'h2fb, 4'hb, 2'b00});
    send(8'hfb, 1'b1);
    repeat (2) data(1'b0);
    bm.stop();
    @(posedge clk_sys) write_protect_input <= 1'b0;
    cmp("write_start", 16'h3, wcount[15:0]);
    @(posedge clk_sys) write_busy <= 1'b1;
    frame(8'hac, 1'b0);
    bm.stop();
    @(posedge clk_sys) write_busy <= 1'b0;
    // consumer stalls: the fifo fills and the next byte is refused
    @(posedge clk_sys) stall <= 1'b1;
    frame(8'hac, 1'b1);
    qa.push_back({10'h23b, 4'hb, 2'b00});
    send(8'h3b, 1'b1);
    n = 0;
    ack = 1'b1;
    while (ack === 1'b1 && n < 8)
    begin
      d8 = seed[11:4];
      bm.xfer(d8, ack);
      if (ack === 1'b1)
        qd.push_back(d8);
      n++;
    end
    // four fifo words plus the output stage are taken, the sixth byte is refused
    cmp("fill", 16'h6, n[15:0]);
    bm.stop();
    @(posedge clk_sys) stall <= 1'b0;
    for (int i = 0; i < 400 && qd.size() != 0; i++)
      @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    cmp("drain", 16'h0, qd.size() != 0);
    cmp("rx_valid", 16'h0, rx_valid);
    summarize();
  end
endmodule // tb
